/* bpcc_pkg.sv */
// Constants shared by the burst and calendar control block
package bpcc_pkg;
	// --------------------------------------------------------------
	// Burst lengths in bytes
	// --------------------------------------------------------------
	localparam int LEN_W = 10;
	localparam logic [LEN_W-1:0] BURST_128 = 10'h080;
	localparam logic [LEN_W-1:0] BURST_256 = 10'h100;
	localparam logic [LEN_W-1:0] SHORT_16  = 10'h010;
	localparam logic [LEN_W-1:0] SHORT_32  = 10'h020;
	localparam logic [LEN_W-1:0] SHORT_64  = 10'h040;
	// --------------------------------------------------------------
	// Datapath widths
	// --------------------------------------------------------------
	localparam int DW_128 = 128;
	localparam int DW_512 = 512;
	// --------------------------------------------------------------
	// Control word layout
	// --------------------------------------------------------------
	localparam int CAL_PAGE_W    = 16;
	localparam int CW_CAL_LSB    = 40;
	localparam int CW_CALRST_BIT = 56;
	localparam int CW_CHAN_BIT   = 32;
	localparam int CW_BURST_BIT  = 63;
	localparam int PAGE_IDX_W    = 4;
	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam int AXI_AW = 8;
	localparam logic [7:0]  REG_CTRL_OFS   = 8'h00;
	localparam logic [7:0]  REG_BURST_OFS  = 8'h04;
	localparam logic [7:0]  REG_CAL_OFS    = 8'h08;
	localparam logic [7:0]  REG_COUNT_OFS  = 8'h0C;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0003;
	localparam int          BURST_SHORT_LSB = 16;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// --------------------------------------------------------------
	// Transmit states
	// --------------------------------------------------------------
	typedef enum logic [0:0] {
		TX_IDLE,
		TX_DATA
	} bpcc_txstate_type;
endpackage

/* bpcc_stream_if.sv */
// Streaming channel between the sorter and a receive port
`timescale 1ns/1ps
`default_nettype none
interface bpcc_stream_if #(
	parameter int DW = 256,
	parameter int EW = 5
);
	logic [DW-1:0] data;
	logic [EW-1:0] empty;
	logic          sop;
	logic          eop;
	logic          valid;
	logic          ready;
	modport src (output data, empty, sop, eop, valid, input ready);
	modport snk (input data, empty, sop, eop, valid, output ready);
endinterface
`default_nettype wire

/* bpcc_burst_cfg.sv */
// Resolves the effective burst-max and burst-short lengths
`timescale 1ns/1ps
`default_nettype none
module bpcc_burst_cfg #(
	parameter int DW              = 256,
	parameter bit DYN_BURST       = 1'b0,
	parameter bit STATIC_MAX_256  = 1'b0,
	parameter bit STATIC_SHORT_64 = 1'b0
) (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	// Run-time selection
	input  wire logic                      burstMaxSel,
	input  wire logic                      burstShortSel,
	// Effective lengths in bytes
	output var  logic [bpcc_pkg::LEN_W-1:0] burstMax_reg,
	output var  logic [bpcc_pkg::LEN_W-1:0] burstShort_reg
);
	logic [bpcc_pkg::LEN_W-1:0] burstMax_next;
	logic [bpcc_pkg::LEN_W-1:0] burstShort_next;

	always_comb begin
		if (DYN_BURST) begin
			burstMax_next = burstMaxSel ? bpcc_pkg::BURST_256 : bpcc_pkg::BURST_128;
		end else begin
			burstMax_next = STATIC_MAX_256 ? bpcc_pkg::BURST_256 : bpcc_pkg::BURST_128;
		end
		if (DW == bpcc_pkg::DW_512) begin
			if (DYN_BURST ? burstShortSel : STATIC_SHORT_64) begin
				burstShort_next = bpcc_pkg::SHORT_64;
			end else begin
				burstShort_next = bpcc_pkg::SHORT_32;
			end
		end else if (DW == bpcc_pkg::DW_128) begin
			burstShort_next = bpcc_pkg::SHORT_16;
		end else begin
			burstShort_next = bpcc_pkg::SHORT_32;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			burstMax_reg   <= bpcc_pkg::BURST_128;
			burstShort_reg <= bpcc_pkg::SHORT_32;
		end else begin
			burstMax_reg   <= burstMax_next;
			burstShort_reg <= burstShort_next;
		end
	end
endmodule // bpcc_burst_cfg
`default_nettype wire

/* bpcc_rx_port.sv */
// Registered output stage of one receive user channel
`timescale 1ns/1ps
`default_nettype none
module bpcc_rx_port #(
	parameter int DW = 256,
	parameter int EW = 5
) (
	// Clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rst,
	// Sorted link data
	bpcc_stream_if.snk         inStream,
	// Application side
	input  wire logic          appReady,
	output var  logic [DW-1:0] data_reg,
	output var  logic [EW-1:0] empty_reg,
	output var  logic          sop_reg,
	output var  logic          eop_reg,
	output var  logic          valid_reg
);
	logic ready_reg;

	assign inStream.ready = ready_reg;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			data_reg  <= '0;
			empty_reg <= '0;
			sop_reg   <= 1'b0;
			eop_reg   <= 1'b0;
			valid_reg <= 1'b0;
			ready_reg <= 1'b1;
		end else begin
			data_reg  <= inStream.data;
			empty_reg <= inStream.empty;
			sop_reg   <= inStream.sop;
			eop_reg   <= inStream.eop;
			valid_reg <= inStream.valid;
			ready_reg <= appReady;
		end
	end
endmodule // bpcc_rx_port
`default_nettype wire

/* bpcc_burst_cal_ctl.sv */
// Burst framing, channel arbitration, sorting and flow-control calendar
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bpcc_burst_cal_ctl #(
	parameter int DW              = 256,
	parameter bit DYN_BURST       = 1'b0,
	parameter bit STATIC_MAX_256  = 1'b0,
	parameter bit STATIC_SHORT_64 = 1'b0,
	parameter bit EXPOSE_CAL      = 1'b0,
	parameter int CAL_PAGES       = 1,
	parameter int EW              = $clog2(DW / 8),
	parameter int CAL_W           = CAL_PAGES * bpcc_pkg::CAL_PAGE_W
) (
	// Clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	// Register bus
	input  wire logic [bpcc_pkg::AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output var  logic                          s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output var  logic                          s_axi_wready,
	output var  logic [1:0]                    s_axi_bresp,
	output var  logic                          s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [bpcc_pkg::AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output var  logic                          s_axi_arready,
	output var  logic [31:0]                   s_axi_rdata,
	output var  logic [1:0]                    s_axi_rresp,
	output var  logic                          s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Transmit user channels
	input  wire logic [1:0][DW-1:0]            txChData,
	input  wire logic [1:0][EW-1:0]            txChEmpty,
	input  wire logic [1:0]                    txChSop,
	input  wire logic [1:0]                    txChEop,
	input  wire logic [1:0]                    txChValid,
	output var  logic [1:0]                    txChReady,
	// Receive user channels
	output var  logic [1:0][DW-1:0]            rxChData,
	output var  logic [1:0][EW-1:0]            rxChEmpty,
	output var  logic [1:0]                    rxChSop,
	output var  logic [1:0]                    rxChEop,
	output var  logic [1:0]                    rxChValid,
	input  wire logic [1:0]                    rxChReady,
	// Run-time burst selection
	input  wire logic                          burstMaxSel,
	input  wire logic                          burstShortSel,
	// Calendar ports
	input  wire logic [CAL_W-1:0]              txCalIn,
	output var  logic [CAL_W-1:0]              rxCalOut,
	// Link transmit
	output var  logic [DW-1:0]                 linkTxData,
	output var  logic                          linkTxCtrl,
	output var  logic                          linkTxSop,
	output var  logic                          linkTxEop,
	output var  logic [EW-1:0]                 linkTxEmpty,
	output var  logic                          linkTxValid,
	input  wire logic                          linkTxReady,
	// Link receive
	input  wire logic [DW-1:0]                 linkRxData,
	input  wire logic                          linkRxCtrl,
	input  wire logic                          linkRxSop,
	input  wire logic                          linkRxEop,
	input  wire logic [EW-1:0]                 linkRxEmpty,
	input  wire logic                          linkRxValid
);
	localparam int LW = bpcc_pkg::LEN_W;
	localparam int PW = bpcc_pkg::PAGE_IDX_W;
	localparam int PG = bpcc_pkg::CAL_PAGE_W;
	localparam logic [PW-1:0] LAST_PAGE = EXPOSE_CAL ? PW'(CAL_PAGES - 1) : '0;
	localparam logic [LW-1:0] BEAT_BYTES = LW'(DW / 8);

	// --------------------------------------------------------------
	// Burst configuration
	// --------------------------------------------------------------
	logic [LW-1:0] burstMax;
	logic [LW-1:0] burstShort;

	bpcc_burst_cfg #(
		.DW              (DW),
		.DYN_BURST       (DYN_BURST),
		.STATIC_MAX_256  (STATIC_MAX_256),
		.STATIC_SHORT_64 (STATIC_SHORT_64)
	) u_cfg (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.burstMaxSel    (burstMaxSel),
		.burstShortSel  (burstShortSel),
		.burstMax_reg   (burstMax),
		.burstShort_reg (burstShort)
	);

	// --------------------------------------------------------------
	// Receive sorting
	// --------------------------------------------------------------
	logic             rxCh_reg, rxCh_next;
	logic [PW-1:0]    rxPage_reg, rxPage_next;
	logic [CAL_W-1:0] rxCal_reg, rxCal_next;
	logic [1:0]       rxSinkReady;
	logic [PW-1:0]    rxPageIdx;

	bpcc_stream_if #(.DW(DW), .EW(EW)) rxSortIf [2] ();

	for (genvar g = 0; g < 2; g++) begin : gRxPort
		assign rxSortIf[g].data  = linkRxData;
		assign rxSortIf[g].empty = linkRxEmpty;
		assign rxSortIf[g].sop   = linkRxSop;
		assign rxSortIf[g].eop   = linkRxEop;
		assign rxSortIf[g].valid = linkRxValid && !linkRxCtrl
			&& (rxCh_reg == 1'(g));
		assign rxSinkReady[g] = rxSortIf[g].ready;

		bpcc_rx_port #(.DW(DW), .EW(EW)) u_port (
			.ref_clk   (ref_clk),
			.rst       (rst),
			.inStream  (rxSortIf[g]),
			.appReady  (rxChReady[g]),
			.data_reg  (rxChData[g]),
			.empty_reg (rxChEmpty[g]),
			.sop_reg   (rxChSop[g]),
			.eop_reg   (rxChEop[g]),
			.valid_reg (rxChValid[g])
		);
	end

	always_comb begin
		rxCh_next   = rxCh_reg;
		rxPage_next = rxPage_reg;
		rxCal_next  = rxCal_reg;
		rxPageIdx   = linkRxData[bpcc_pkg::CW_CALRST_BIT] ? '0 : rxPage_reg;
		if (linkRxValid && linkRxCtrl) begin
			rxCh_next = linkRxData[bpcc_pkg::CW_CHAN_BIT];
			rxCal_next[32'(rxPageIdx) * PG +: PG] =
				linkRxData[bpcc_pkg::CW_CAL_LSB +: PG];
			rxPage_next = (rxPageIdx == LAST_PAGE) ? '0 : rxPageIdx + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rxCh_reg   <= 1'b0;
			rxPage_reg <= '0;
			rxCal_reg  <= '1;
		end else begin
			rxCh_reg   <= rxCh_next;
			rxPage_reg <= rxPage_next;
			rxCal_reg  <= rxCal_next;
		end
	end

	assign rxCalOut = rxCal_reg;

	// --------------------------------------------------------------
	// Transmit arbitration and burst framing
	// --------------------------------------------------------------
	bpcc_pkg::bpcc_txstate_type state_reg, state_next;
	logic          curCh_reg, curCh_next;
	logic [LW-1:0] count_reg, count_next;
	logic [PW-1:0] txPage_reg, txPage_next;
	logic [1:0]    ready_reg, ready_next;
	logic [DW-1:0] oData_reg, oData_next;
	logic          oCtrl_reg, oCtrl_next;
	logic          oSop_reg, oSop_next;
	logic          oEop_reg, oEop_next;
	logic [EW-1:0] oEmpty_reg, oEmpty_next;
	logic          oValid_reg, oValid_next;
	logic [31:0]   bursts_reg, bursts_next;
	logic [31:0]   ctrl_reg;
	logic [1:0]    txXon;
	logic [1:0]    cand;
	logic          pick;
	logic [PG-1:0] txPageBits;
	logic [LW-1:0] beatCount;

	always_comb begin
		txXon = EXPOSE_CAL ? 2'h3 : rxCal_reg[1:0];
		cand  = txChValid & txXon & ctrl_reg[1:0];
		pick  = cand[~curCh_reg] ? ~curCh_reg : curCh_reg;
		if (EXPOSE_CAL) begin
			txPageBits = txCalIn[32'(txPage_reg) * PG +: PG];
		end else begin
			txPageBits = {{(PG - 2){1'b0}}, rxSinkReady};
		end
		beatCount   = count_reg + BEAT_BYTES - LW'(txChEmpty[curCh_reg]);
		state_next  = state_reg;
		curCh_next  = curCh_reg;
		count_next  = count_reg;
		txPage_next = txPage_reg;
		ready_next  = 2'h0;
		oData_next  = oData_reg;
		oCtrl_next  = oCtrl_reg;
		oSop_next   = oSop_reg;
		oEop_next   = oEop_reg;
		oEmpty_next = oEmpty_reg;
		oValid_next = oValid_reg && !linkTxReady;
		bursts_next = bursts_reg;
		case (state_reg)
			bpcc_pkg::TX_IDLE: begin
				if (!oValid_next && (cand != 2'h0)) begin
					oData_next = '0;
					oData_next[bpcc_pkg::CW_BURST_BIT]  = 1'b1;
					oData_next[bpcc_pkg::CW_CHAN_BIT]   = pick;
					oData_next[bpcc_pkg::CW_CALRST_BIT] = (txPage_reg == '0);
					oData_next[bpcc_pkg::CW_CAL_LSB +: PG] = txPageBits;
					oCtrl_next  = 1'b1;
					oSop_next   = 1'b0;
					oEop_next   = 1'b0;
					oEmpty_next = '0;
					oValid_next = 1'b1;
					txPage_next = (txPage_reg == LAST_PAGE) ? '0
						: txPage_reg + 1'b1;
					curCh_next  = pick;
					count_next  = '0;
					bursts_next = bursts_reg + 32'h0000_0001;
					state_next  = bpcc_pkg::TX_DATA;
				end
			end
			bpcc_pkg::TX_DATA: begin
				if (ready_reg[curCh_reg] && txChValid[curCh_reg]) begin
					oData_next  = txChData[curCh_reg];
					oCtrl_next  = 1'b0;
					oSop_next   = txChSop[curCh_reg];
					oEop_next   = txChEop[curCh_reg];
					oEmpty_next = txChEmpty[curCh_reg];
					oValid_next = 1'b1;
					count_next  = beatCount;
					// burst ends at eop, at max size, or, with EXPOSE_CAL clear, at short size when the channel is off in the calendar
					if (txChEop[curCh_reg] || (beatCount >= burstMax)) begin
						state_next = bpcc_pkg::TX_IDLE;
					end else if (!txXon[curCh_reg] && (beatCount >= burstShort)) begin
						state_next = bpcc_pkg::TX_IDLE;
					end
				end else if (!oValid_next) begin
					ready_next[curCh_reg] = 1'b1;
				end
			end
			default: begin
				state_next = bpcc_pkg::TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg  <= bpcc_pkg::TX_IDLE;
			curCh_reg  <= 1'b1;
			count_reg  <= '0;
			txPage_reg <= '0;
			ready_reg  <= 2'h0;
			oData_reg  <= '0;
			oCtrl_reg  <= 1'b0;
			oSop_reg   <= 1'b0;
			oEop_reg   <= 1'b0;
			oEmpty_reg <= '0;
			oValid_reg <= 1'b0;
			bursts_reg <= 32'h0000_0000;
		end else begin
			state_reg  <= state_next;
			curCh_reg  <= curCh_next;
			count_reg  <= count_next;
			txPage_reg <= txPage_next;
			ready_reg  <= ready_next;
			oData_reg  <= oData_next;
			oCtrl_reg  <= oCtrl_next;
			oSop_reg   <= oSop_next;
			oEop_reg   <= oEop_next;
			oEmpty_reg <= oEmpty_next;
			oValid_reg <= oValid_next;
			bursts_reg <= bursts_next;
		end
	end

	assign txChReady   = ready_reg;
	assign linkTxData  = oData_reg;
	assign linkTxCtrl  = oCtrl_reg;
	assign linkTxSop   = oSop_reg;
	assign linkTxEop   = oEop_reg;
	assign linkTxEmpty = oEmpty_reg;
	assign linkTxValid = oValid_reg;

	// --------------------------------------------------------------
	// Register bus slave
	// --------------------------------------------------------------
	logic                       awHeld_reg, awHeld_next;
	logic                       wHeld_reg, wHeld_next;
	logic [bpcc_pkg::AXI_AW-1:0] awAddr_reg, awAddr_next;
	logic [31:0]                wData_reg, wData_next;
	logic                       wStrb0_reg, wStrb0_next;
	logic [31:0]                ctrl_next;
	logic                       awready_reg, awready_next;
	logic                       wready_reg, wready_next;
	logic                       bvalid_reg, bvalid_next;
	logic [1:0]                 bresp_reg, bresp_next;
	logic                       arready_reg, arready_next;
	logic                       rvalid_reg, rvalid_next;
	logic [1:0]                 rresp_reg, rresp_next;
	logic [31:0]                rdata_reg, rdata_next;

	always_comb begin
		awHeld_next  = awHeld_reg;
		wHeld_next   = wHeld_reg;
		awAddr_next  = awAddr_reg;
		wData_next   = wData_reg;
		wStrb0_next  = wStrb0_reg;
		ctrl_next    = ctrl_reg;
		bvalid_next  = bvalid_reg && !s_axi_bready;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg && !s_axi_rready;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (s_axi_awvalid && awready_reg) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			wHeld_next  = 1'b1;
			wData_next  = s_axi_wdata;
			wStrb0_next = s_axi_wstrb[0];
		end
		if (awHeld_next && wHeld_next && !bvalid_reg) begin
			awHeld_next = 1'b0;
			wHeld_next  = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = bpcc_pkg::RESP_OKAY;
			case (awAddr_next)
				bpcc_pkg::REG_CTRL_OFS: begin
					if (wStrb0_next) begin
						ctrl_next = {30'h0000_0000, wData_next[1:0]};
					end
				end
				bpcc_pkg::REG_BURST_OFS, bpcc_pkg::REG_CAL_OFS,
				bpcc_pkg::REG_COUNT_OFS: begin
					bresp_next = bpcc_pkg::RESP_OKAY;
				end
				default: begin
					bresp_next = bpcc_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s_axi_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = bpcc_pkg::RESP_OKAY;
			rdata_next  = 32'h0000_0000;
			case (s_axi_araddr)
				bpcc_pkg::REG_CTRL_OFS: rdata_next = ctrl_reg;
				bpcc_pkg::REG_BURST_OFS: begin
					rdata_next[LW-1:0] = burstMax;
					rdata_next[bpcc_pkg::BURST_SHORT_LSB +: LW] = burstShort;
				end
				bpcc_pkg::REG_CAL_OFS: begin
					rdata_next = {txPageBits, rxCal_reg[PG-1:0]};
				end
				bpcc_pkg::REG_COUNT_OFS: rdata_next = bursts_reg;
				default: rresp_next = bpcc_pkg::RESP_SLVERR;
			endcase
		end
		awready_next = !awHeld_next && !bvalid_next;
		wready_next  = !wHeld_next && !bvalid_next;
		arready_next = !rvalid_next;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			awHeld_reg  <= 1'b0;
			wHeld_reg   <= 1'b0;
			awAddr_reg  <= '0;
			wData_reg   <= 32'h0000_0000;
			wStrb0_reg  <= 1'b0;
			ctrl_reg    <= bpcc_pkg::CTRL_RESET;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= bpcc_pkg::RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= bpcc_pkg::RESP_OKAY;
			rdata_reg   <= 32'h0000_0000;
		end else begin
			awHeld_reg  <= awHeld_next;
			wHeld_reg   <= wHeld_next;
			awAddr_reg  <= awAddr_next;
			wData_reg   <= wData_next;
			wStrb0_reg  <= wStrb0_next;
			ctrl_reg    <= ctrl_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
endmodule // bpcc_burst_cal_ctl
`default_nettype wire

/* bpcc_ctl_sva.sv */
// Checker bound to the burst and calendar block
`timescale 1ns/1ps
`default_nettype none
module bpcc_ctl_sva #(
	parameter int DW = 256,
	parameter int EW = 5,
	parameter int CAL_W = 16
) (
	// Clock and reset
	input wire logic	ref_clk,
	input wire logic	rst,
	// Register bus
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	// Receive user channels and receive calendar
	input wire logic [1:0]	rxChValid,
	input wire logic [1:0][EW-1:0]	rxChEmpty,
	input wire logic [CAL_W-1:0]	rxCalOut,
	// Link transmit
	input wire logic [DW-1:0]	linkTxData,
	input wire logic	linkTxCtrl,
	input wire logic	linkTxValid,
	input wire logic	linkTxReady,
	// Link receive
	input wire logic [DW-1:0]	linkRxData,
	input wire logic	linkRxCtrl,
	input wire logic [EW-1:0]	linkRxEmpty,
	input wire logic	linkRxValid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_cw_layout: assert property (linkTxValid && linkTxCtrl
		|-> linkTxData[63] && linkTxData[31:0] == 32'h0) else $error("cw layout");
	chk_tx_hold: assert property (linkTxValid && !linkTxReady
		|=> linkTxValid && $stable(linkTxData)) else $error("tx not held");
	chk_b_stand: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("bvalid dropped");
	chk_rx_onehot: assert property (rxChValid != 2'h3)
		else $error("two rx channels at once");
	chk_rx_delay: assert property (linkRxValid && !linkRxCtrl
		|=> rxChValid != 2'h0) else $error("rx beat lost");
	chk_rx_empty: assert property (rxChValid != 2'h0
		|-> rxChEmpty[rxChValid[1]] == $past(linkRxEmpty)) else $error("empty");
	chk_cal_store: assert property (linkRxValid && linkRxCtrl
		&& linkRxData[56] |=> rxCalOut[15:0] == $past(linkRxData[55:40]))
		else $error("rx calendar page");
	chk_no_stray: assert property (rxChValid != 2'h0
		|-> $past(linkRxValid) && !$past(linkRxCtrl)) else $error("stray rx");
endmodule // bpcc_ctl_sva
bind bpcc_burst_cal_ctl bpcc_ctl_sva #(.DW(DW), .EW(EW), .CAL_W(CAL_W))
	bpcc_ctl_sva_inst (.*);
`default_nettype wire

/* bpcc_app_src.sv */
// Application source model for the two transmit channels
`timescale 1ns/1ps
`default_nettype none
module bpcc_app_src #(
	parameter int DW = 128,
	parameter int EW = 4
) (
	// Clock and reset
	input wire logic	ref_clk,
	input wire logic	rst,
	// Packet request
	input wire logic	appStart,
	input wire logic	appCh,
	// Transmit channels
	input wire logic [1:0]	txChReady,
	output var logic [1:0][DW-1:0]	txChData,
	output var logic [1:0][EW-1:0]	txChEmpty,
	output var logic [1:0]	txChSop,
	output var logic [1:0]	txChEop,
	output var logic [1:0]	txChValid
);
	logic [1:0]	left;
	logic [DW-1:0]	pay;
	assign txChEmpty = {2{EW'(left)}};
	assign txChData = {pay, ~pay};
	assign txChSop = {2{left == 2'h2}};
	assign txChEop = {2{left == 2'h0}};
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			txChValid <= 2'h0;
			left <= 2'h0;
			pay <= '0;
		end else if (appStart) begin
			txChValid[appCh] <= 1'b1;
			left <= 2'h2;
		end else if ((txChValid & txChReady) != 2'h0) begin
			pay <= pay + DW'(1);
			left <= left - 2'h1;
			if (left == 2'h0)
				txChValid <= 2'h0;
		end
	end
endmodule // bpcc_app_src
`default_nettype wire

/* bpcc_burst_cal_ctl_tb.sv */
// Testbench for the burst and calendar block
`timescale 1ns/1ps
`default_nettype none
module bpcc_burst_cal_ctl_tb;
	localparam int DW = 128;
	localparam int EW = 4;
	logic ref_clk = 1'b0, rst = 1'b1, appStart = 1'b0, appCh = 1'b0, curCh;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, rxChReady = 2'h3;
	logic [1:0][DW-1:0] txChData, rxChData;
	logic [1:0][EW-1:0] txChEmpty, rxChEmpty;
	logic [1:0] txChSop, txChEop, txChValid, txChReady, rxChSop, rxChEop;
	logic [1:0] rxChValid;
	logic burstMaxSel = 1'b0, burstShortSel = 1'b0, linkTxReady = 1'b0;
	logic [15:0] txCalIn = 16'h0, rxCalOut, pg;
	logic [DW-1:0] linkTxData, linkRxData = '0;
	logic [EW-1:0] linkTxEmpty, linkRxEmpty = '0;
	logic linkTxCtrl, linkTxSop, linkTxEop, linkTxValid, linkRxValid = 1'b0;
	logic linkRxCtrl = 1'b0, linkRxSop = 1'b0, linkRxEop = 1'b0;
	logic [31:0] rnd = 32'h9445CD5A;
	logic [36:0] rxq[$];
	logic txq[$];
	int fail_count = 0, checked = 0, txBeats = 0;
	bpcc_burst_cal_ctl #(.DW(DW)) bpcc_burst_cal_ctl_inst (.*);
	bpcc_app_src #(.DW(DW), .EW(EW)) bpcc_app_src_inst (.*);
	always #4 ref_clk = ~ref_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected sop, eop and empty of link data beat n
	function automatic logic [5:0] bexp(input int n);
		return {n % 3 == 0, n % 3 == 2, EW'(2 - n % 3)};
	endfunction
	function automatic logic [DW-1:0] cw(input logic c, input logic [15:0] p);
		cw = '0;
		cw[63] = 1'b1;
		cw[56] = 1'b1;
		cw[55:40] = p;
		cw[32] = c;
	endfunction
	task automatic chk(input logic [36:0] g, input logic [36:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit ad, dd;
		ad = 0;
		dd = 0;
		@(posedge ref_clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		while (!(ad && dd)) begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1 && !ad) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1 && !dd) begin
				dd = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		// Late bready makes the response wait
		@(posedge ref_clk);
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		{got, resp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	task automatic rx_beat(input logic c, input logic [DW-1:0] d,
		input logic [EW-1:0] e);
		@(posedge ref_clk);
		{linkRxValid, linkRxCtrl, linkRxData, linkRxEmpty} <= {1'b1, c, d, e};
		if (c)
			curCh = d[32];
		else
			rxq.push_back({curCh, e, d[31:0]});
	endtask
	always @(posedge ref_clk) begin
		rnd <= lfsr(rnd);
		linkTxReady <= rnd[0];
		rxChReady <= rnd[4:3];
		txCalIn <= rnd[31:16];
		if (txChValid == 2'h0)
			{burstMaxSel, burstShortSel} <= rnd[2:1];
		for (int c = 0; c < 2; c++)
			if (rxChValid[c] === 1'b1)
				chk({c[0], rxChEmpty[c], rxChData[c][31:0]}, rxq.pop_front());
		if ((linkTxValid & linkTxReady & linkTxCtrl) === 1'b1)
			chk(linkTxData[32], txq.pop_front());
		if ((linkTxValid & linkTxReady & ~linkTxCtrl) === 1'b1) begin
			chk({linkTxSop, linkTxEop, linkTxEmpty}, bexp(txBeats));
			txBeats++;
		end
	end
	initial begin
		repeat (4000) @(posedge ref_clk);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		axi_rd(bpcc_pkg::REG_CTRL_OFS);
		chk(got, bpcc_pkg::CTRL_RESET);
		axi_rd(bpcc_pkg::REG_BURST_OFS);
		chk(got, {6'h0, bpcc_pkg::SHORT_16,
			6'h0, bpcc_pkg::BURST_128});
		axi_rd(8'h10);
		chk(resp, bpcc_pkg::RESP_SLVERR);
		axi_wr(8'h10, 32'h0);
		chk(resp, bpcc_pkg::RESP_SLVERR);
		axi_wr(bpcc_pkg::REG_CTRL_OFS, 32'h1);
		chk(resp, bpcc_pkg::RESP_OKAY);
		axi_rd(bpcc_pkg::REG_CTRL_OFS);
		chk(got, 32'h1);
		axi_wr(bpcc_pkg::REG_CTRL_OFS, bpcc_pkg::CTRL_RESET);
		for (int c = 0; c < 2; c++) begin
			txq.push_back(c[0]);
			appCh <= c[0];
			appStart <= 1'b1;
			@(posedge ref_clk);
			appStart <= 1'b0;
			for (int i = 0; i < 300 && txBeats < 3 * (c + 1); i++)
				@(posedge ref_clk);
		end
		chk(txBeats, 6);
		axi_rd(bpcc_pkg::REG_COUNT_OFS);
		chk(got, 32'h2);
		for (int c = 0; c < 2; c++) begin
			pg = rnd[15:0] | 16'h0003;
			rx_beat(1'b1, cw(c[0], pg), 4'h0);
			repeat (2) rx_beat(1'b0, {4{rnd}}, rnd[7:4]);
		end
		@(posedge ref_clk);
		{linkRxValid, linkRxData} <= {1'b0, ~linkRxData};
		repeat (3) @(posedge ref_clk);
		axi_rd(bpcc_pkg::REG_CAL_OFS);
		chk(got[15:0], pg);
		chk(rxq.size(), 0);
		tally_and_finish();
	end
endmodule // bpcc_burst_cal_ctl_tb
`default_nettype wire
